// ### rtl/ubd_pkg.sv
package ubd_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, low address bits decoded)
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_DIV_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_DIV_STEP  = 8'h04;
  localparam logic [7:0]  OFS_DIV_RES   = 8'h08;
  localparam logic [7:0]  OFS_BAUD      = 8'h0c;
  localparam logic [7:0]  OFS_UART      = 8'h10;
  localparam logic [7:0]  OFS_LIN_CTRL  = 8'h14;
  localparam logic [7:0]  OFS_LIN_STAT  = 8'h18;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h1c;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          B_DIV_EN      = 0;
  localparam int          B_DIV_MODE    = 1;
  localparam int          B_DIV_OVF     = 2;
  localparam int          B_BAUD_RUN    = 16;
  localparam int          B_PRE_LO      = 8;
  localparam int          B_T1_SEL      = 2;
  localparam int          B_DOUBLE      = 3;
  localparam int          B_LIN_EN      = 0;
  localparam int          B_LIN_MASTER  = 1;
  localparam int          B_LIN_AUTO    = 2;
  localparam int          B_BRK_LEN_LO  = 8;
  localparam int          B_BRK_START   = 31;
  localparam int          B_STATE_LO    = 16;
  localparam int          B_BRK_BUSY    = 24;

  // Interrupt status bit positions
  localparam int          IRQ_NORMAL_DIVIDER_OVERFLOW_FLAG      = 0;
  localparam int          IRQ_SYNC      = 1;
  localparam int          IRQ_BRK       = 2;
  localparam int          IRQ_MERR      = 3;
  localparam int          IRQ_N         = 4;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  CNT_MAX       = 8'hff;
  localparam logic [7:0]  CNT_ZERO      = 8'h00;
  localparam logic [7:0]  BRK_MIN_BITS  = 8'h0d;
  localparam logic [3:0]  OVS_LAST      = 4'hf;
  localparam logic [3:0]  SHIFT_BASE    = 4'h7;
  localparam logic [15:0] MEAS_MAX      = 16'hffff;
  localparam logic [15:0] BRK_DET_MIN   = 16'h03e8;
  localparam logic [2:0]  SYNC_FALLS    = 3'h4;
  localparam logic [1:0]  UART_MODE1    = 2'h1;
  localparam logic [1:0]  UART_MODE3    = 2'h3;
  localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE     = 5'b00001,
    ST_WAIT_BRK = 5'b00010,
    ST_BRK      = 5'b00100,
    ST_WAIT_SYN = 5'b01000,
    ST_MEAS     = 5'b10000
  } ubd_lin_state_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ubd_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ubd_ahb_rsp_t;

endpackage

// ### rtl/ubd_down_timer.sv
`timescale 1ns/1ps
module ubd_down_timer
  import ubd_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic [7:0] reload,
  output logic [7:0]      count,
  output logic            uflow
);
  assign uflow = run & tick & (count == CNT_ZERO);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= CNT_ZERO;
    end else if (ce && run && tick) begin
      count <= uflow ? reload : count - 8'h01;
    end
  end

  AST_BT_RELOAD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    uflow && ce |=> count == $past(reload))
    else $error("baud timer did not reload on underflow");
endmodule

// ### rtl/ubd_up_timer.sv
`timescale 1ns/1ps
module ubd_up_timer
  import ubd_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       en,
  input  wire logic       tick,
  input  wire logic [7:0] step,
  output logic [7:0]      count,
  output logic            ovf
);
  assign ovf = en & tick & (count == CNT_MAX);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= CNT_ZERO;
    end else if (ce) begin
      if (!en) begin
        count <= step;
      end else if (tick) begin
        count <= ovf ? step : count + 8'h01;
      end
    end
  end

  AST_ND_INC: assert property (@(posedge sys_clk) disable iff (!rst_n)
    en && tick && ce && !ovf |=> count == $past(count) + 8'h01)
    else $error("normal divider did not count up");
  AST_ND_RELOAD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ovf && ce |=> count == $past(step))
    else $error("normal divider did not reload step");
endmodule

// ### rtl/ubd_top.sv
// What this block does
// - Timer 1 overflows clock baud in modes 1,3
// - Timer 1 baud scaled by double-rate bit
// - Divider mode select stops dedicated baud generator
// - Normal divider counts up from reload value
// - Result shows count, step is reload
// - Divider overflow sets flag and interrupt
// - Divider output is input over 256-step
// - Only a LIN master sends a header
// - Break stays dominant thirteen bits or more
// - Frame: break, synch 55, identifier, data
// - Break made apart from ordinary UART bytes
// - Baud rate measured by a timer
// - Setup, wait frame, adopt rate, then serve
// - Rate measured again on every header
// - Baud timer reloads and ticks per underflow
`timescale 1ns/1ps
module ubd_top
  import ubd_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  ubd_pkg::ubd_ahb_req_t ahb_req,
  output ubd_pkg::ubd_ahb_rsp_t ahb_rsp,
  input  wire logic          t1_ovf,
  input  wire logic          uart_txd,
  input  wire logic          lin_rxd,
  output logic               baud_tick,
  output logic               fmod_tick,
  output logic               lin_txd,
  output logic               irq
);
  import ubd_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic           divider_enable;
  logic           divider_mode_select;
  logic [7:0]     divider_step_reg;
  logic [7:0]     divider_result_reg;
  logic [7:0]     baud_reload_value;
  logic [2:0]     baud_prescale_field;
  logic           baud_run;
  logic [1:0]     uart_mode;
  logic           t1_sel;
  logic           baud_double_bit;
  logic           lin_en;
  logic           lin_master;
  logic           lin_auto;
  logic [7:0]     brk_len;
  logic [IRQ_N-1:0] irq_status;
  logic [IRQ_N-1:0] irq_mask;
  logic [15:0]    meas_val;

  // Bus pipeline
  logic           wr_pend;
  logic [7:0]     wr_addr;
  logic           acc;
  logic           wr_now;
  logic [31:0]    wdat;
  logic [31:0]    rd_mux;
  logic [IRQ_N-1:0] irq_clr;
  logic [IRQ_N-1:0] irq_ev;

  // Baud path
  logic [7:0]     pre_cnt;
  logic [7:0]     pre_mask;
  logic           fdiv_tick;
  logic [8:0]     frac_acc;
  logic           frac_carry;
  logic           norm_mode;
  logic           ndiv_ovf;
  logic           fmod_int;
  logic           bt_tick;
  logic           bt_run;
  logic           bt_uflow;
  logic           t1_active;
  logic           t1_half;
  logic           baud_int;

  // LIN
  ubd_lin_state_t lin_state;
  logic [15:0]    meas_cnt;
  logic [2:0]     fall_cnt;
  logic           rxd_q;
  logic           rxd_fall;
  logic           rxd_rise;
  logic           adopt;
  logic           meas_err;
  logic [3:0]     shift_n;
  logic [15:0]    meas_scaled;
  logic           brk_active;
  logic           brk_done;
  logic           brk_start;
  logic [3:0]     ovs_cnt;
  logic [7:0]     bit_cnt;
  logic [7:0]     brk_len_eff;

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  assign acc    = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
  assign wr_now = wr_pend;
  assign wdat   = ahb_req.hwdata;

  always_comb begin
    rd_mux = RD_ZERO;
    if (ahb_req.haddr[ADDR_W-1:0] == OFS_DIV_CTRL) begin
      rd_mux[B_DIV_EN]   = divider_enable;
      rd_mux[B_DIV_MODE] = divider_mode_select;
      rd_mux[B_DIV_OVF]  = irq_status[IRQ_NORMAL_DIVIDER_OVERFLOW_FLAG];
    end else if (ahb_req.haddr[ADDR_W-1:0] == OFS_DIV_STEP) begin
      rd_mux[7:0] = divider_step_reg;
    end else if (ahb_req.haddr[ADDR_W-1:0] == OFS_DIV_RES) begin
      rd_mux[7:0] = divider_result_reg;
    end else if (ahb_req.haddr[ADDR_W-1:0] == OFS_BAUD) begin
      rd_mux[7:0]                = baud_reload_value;
      rd_mux[B_PRE_LO+:3]        = baud_prescale_field;
      rd_mux[B_BAUD_RUN]         = baud_run;
    end else if (ahb_req.haddr[ADDR_W-1:0] == OFS_UART) begin
      rd_mux[1:0]      = uart_mode;
      rd_mux[B_T1_SEL] = t1_sel;
      rd_mux[B_DOUBLE] = baud_double_bit;
    end else if (ahb_req.haddr[ADDR_W-1:0] == OFS_LIN_CTRL) begin
      rd_mux[B_LIN_EN]          = lin_en;
      rd_mux[B_LIN_MASTER]      = lin_master;
      rd_mux[B_LIN_AUTO]        = lin_auto;
      rd_mux[B_BRK_LEN_LO+:8]   = brk_len;
    end else if (ahb_req.haddr[ADDR_W-1:0] == OFS_LIN_STAT) begin
      rd_mux[15:0]              = meas_val;
      rd_mux[B_STATE_LO+:5]     = lin_state;
      rd_mux[B_BRK_BUSY]        = brk_active;
    end else if (ahb_req.haddr[ADDR_W-1:0] == OFS_IRQ_STAT) begin
      rd_mux[IRQ_N-1:0] = irq_status;
    end else if (ahb_req.haddr[ADDR_W-1:0] == OFS_IRQ_MASK) begin
      rd_mux[IRQ_N-1:0] = irq_mask;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= OFS_DIV_CTRL;
      ahb_rsp <= '{hrdata: RD_ZERO, hreadyout: 1'b1, hresp: 1'b0};
    end else begin
      wr_pend           <= acc & ahb_req.hwrite;
      ahb_rsp.hreadyout <= 1'b1;
      ahb_rsp.hresp     <= 1'b0;
      if (acc) begin
        wr_addr <= ahb_req.haddr[ADDR_W-1:0];
      end
      if (acc && !ahb_req.hwrite) begin
        ahb_rsp.hrdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  assign shift_n     = SHIFT_BASE + {1'b0, baud_prescale_field};
  assign meas_scaled = (meas_cnt + 16'h0001) >> shift_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divider_enable      <= 1'b0;
      divider_mode_select <= 1'b0;
      divider_step_reg    <= CNT_ZERO;
      baud_reload_value   <= CNT_ZERO;
      baud_prescale_field <= 3'h0;
      baud_run            <= 1'b0;
      uart_mode           <= 2'h0;
      t1_sel              <= 1'b0;
      baud_double_bit     <= 1'b0;
      lin_en              <= 1'b0;
      lin_master          <= 1'b0;
      lin_auto            <= 1'b0;
      brk_len             <= BRK_MIN_BITS;
      irq_mask            <= '0;
    end else begin
      if (wr_now && wr_addr == OFS_DIV_CTRL) begin
        divider_enable      <= wdat[B_DIV_EN];
        divider_mode_select <= wdat[B_DIV_MODE];
      end else if (wr_now && wr_addr == OFS_DIV_STEP) begin
        divider_step_reg <= wdat[7:0];
      end else if (wr_now && wr_addr == OFS_BAUD) begin
        baud_reload_value   <= wdat[7:0];
        baud_prescale_field <= wdat[B_PRE_LO+:3];
        baud_run            <= wdat[B_BAUD_RUN];
      end else if (wr_now && wr_addr == OFS_UART) begin
        uart_mode       <= wdat[1:0];
        t1_sel          <= wdat[B_T1_SEL];
        baud_double_bit <= wdat[B_DOUBLE];
      end else if (wr_now && wr_addr == OFS_LIN_CTRL) begin
        lin_en     <= wdat[B_LIN_EN];
        lin_master <= wdat[B_LIN_MASTER];
        lin_auto   <= wdat[B_LIN_AUTO];
        brk_len    <= wdat[B_BRK_LEN_LO+:8];
      end else if (wr_now && wr_addr == OFS_IRQ_MASK) begin
        irq_mask <= wdat[IRQ_N-1:0];
      end
      // Measured bit time becomes the new baud reload
      if (ce && adopt && lin_auto && meas_scaled != 16'h0000) begin
        baud_reload_value <= meas_scaled[7:0] - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and fractional / normal divider
  // ----------------------------------------------------------------
  assign pre_mask  = (8'h01 << baud_prescale_field) - 8'h01;
  assign fdiv_tick = (pre_cnt & pre_mask) == pre_mask;
  assign norm_mode = divider_enable & divider_mode_select;
  assign fmod_int  = norm_mode ? ndiv_ovf : frac_carry;
  assign frac_carry = divider_enable & fdiv_tick & frac_acc[8];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt  <= CNT_ZERO;
      frac_acc <= 9'h000;
    end else if (ce) begin
      pre_cnt <= pre_cnt + 8'h01;
      if (divider_enable && !divider_mode_select && fdiv_tick) begin
        frac_acc <= {1'b0, frac_acc[7:0]} + {1'b0, divider_step_reg};
      end else if (!divider_enable) begin
        frac_acc <= 9'h000;
      end
    end
  end

  ubd_up_timer u_ndiv (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .en      (norm_mode),
    .tick    (fdiv_tick),
    .step    (divider_step_reg),
    .count   (divider_result_reg),
    .ovf     (ndiv_ovf)
  );

  // ----------------------------------------------------------------
  // Dedicated baud timer and Timer 1 source
  // ----------------------------------------------------------------
  assign bt_tick   = divider_enable ? frac_carry : fdiv_tick;
  assign bt_run    = baud_run & ~norm_mode;
  assign t1_active = t1_sel &
                     (uart_mode == UART_MODE1 || uart_mode == UART_MODE3);
  // Oversampling tick: each overflow with double rate, else every second
  assign baud_int  = t1_active ?
                     (ce & t1_ovf & (baud_double_bit | t1_half)) :
                     bt_uflow;

  ubd_down_timer u_bt (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .run     (bt_run),
    .tick    (bt_tick),
    .reload  (baud_reload_value),
    .count   (),
    .uflow   (bt_uflow)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      t1_half   <= 1'b0;
      baud_tick <= 1'b0;
      fmod_tick <= 1'b0;
    end else if (ce) begin
      if (t1_active && t1_ovf) begin
        t1_half <= ~t1_half;
      end
      baud_tick <= baud_int;
      fmod_tick <= fmod_int;
    end
  end

  // ----------------------------------------------------------------
  // Break generator, master only
  // ----------------------------------------------------------------
  // Length comes with the start write itself
  assign brk_len_eff = (wdat[B_BRK_LEN_LO+:8] < BRK_MIN_BITS) ?
                       BRK_MIN_BITS : wdat[B_BRK_LEN_LO+:8];
  assign brk_start   = wr_now && wr_addr == OFS_LIN_CTRL &&
                       wdat[B_BRK_START] && wdat[B_LIN_MASTER];
  assign brk_done    = ce & brk_active & baud_int & (ovs_cnt == OVS_LAST) &
                       (bit_cnt == 8'h01);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      brk_active <= 1'b0;
      ovs_cnt    <= 4'h0;
      bit_cnt    <= CNT_ZERO;
    end else if (brk_start && !brk_active) begin
      brk_active <= 1'b1;
      ovs_cnt    <= 4'h0;
      bit_cnt    <= brk_len_eff;
    end else if (ce && brk_active) begin
      if (!lin_master || brk_done) begin
        brk_active <= 1'b0;
      end else if (baud_int) begin
        ovs_cnt <= ovs_cnt + 4'h1;
        if (ovs_cnt == OVS_LAST) begin
          bit_cnt <= bit_cnt - 8'h01;
        end
      end
    end
  end

  // Break overrides the UART byte stream on the line
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lin_txd <= 1'b1;
    end else if (ce) begin
      lin_txd <= brk_active ? 1'b0 : uart_txd;
    end
  end

  // ----------------------------------------------------------------
  // Header watcher: break, then synch byte bit-time measurement
  // ----------------------------------------------------------------
  assign rxd_fall = rxd_q & ~lin_rxd;
  assign rxd_rise = ~rxd_q & lin_rxd;
  assign adopt    = lin_state == ST_MEAS && rxd_fall &&
                    fall_cnt == SYNC_FALLS - 3'h1;
  assign meas_err = ce & (lin_state == ST_MEAS || lin_state == ST_BRK) &
                    (meas_cnt == MEAS_MAX);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_q     <= 1'b1;
      lin_state <= ST_IDLE;
      meas_cnt  <= 16'h0000;
      fall_cnt  <= 3'h0;
      meas_val  <= 16'h0000;
    end else if (ce) begin
      rxd_q <= lin_rxd;
      if (!lin_en) begin
        lin_state <= ST_IDLE;
      end else begin
        case (lin_state)
          ST_IDLE: begin
            meas_cnt  <= 16'h0000;
            lin_state <= ST_WAIT_BRK;
          end
          ST_WAIT_BRK: begin
            meas_cnt <= 16'h0000;
            if (rxd_fall) begin
              lin_state <= ST_BRK;
            end
          end
          ST_BRK: begin
            meas_cnt <= meas_cnt + 16'h0001;
            if (meas_err) begin
              lin_state <= ST_WAIT_BRK;
            end else if (rxd_rise) begin
              lin_state <= (meas_cnt >= BRK_DET_MIN) ? ST_WAIT_SYN
                                                     : ST_WAIT_BRK;
            end
          end
          ST_WAIT_SYN: begin
            meas_cnt <= 16'h0000;
            fall_cnt <= 3'h0;
            if (rxd_fall) begin
              lin_state <= ST_MEAS;
            end
          end
          ST_MEAS: begin
            meas_cnt <= meas_cnt + 16'h0001;
            if (meas_err) begin
              lin_state <= ST_WAIT_BRK;
            end else if (adopt) begin
              meas_val  <= meas_cnt + 16'h0001;
              lin_state <= ST_WAIT_BRK;
            end else if (rxd_fall) begin
              fall_cnt <= fall_cnt + 3'h1;
            end
          end
          default: begin
            lin_state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  assign irq_clr = (wr_now && wr_addr == OFS_IRQ_STAT) ? wdat[IRQ_N-1:0]
                                                      : '0;
  assign irq_ev  = {meas_err, brk_done, ce & adopt, ce & ndiv_ovf};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_ev;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_NORMAL_DIVIDER_OVERFLOW_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ce && ndiv_ovf |=> irq_status[IRQ_NORMAL_DIVIDER_OVERFLOW_FLAG])
    else $error("overflow flag not set");
  AST_NORM_STOPS_BT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    norm_mode |-> !bt_uflow)
    else $error("baud timer ran in normal divider mode");
  AST_T1_DOUBLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ce && t1_active && baud_double_bit && t1_ovf |=> baud_tick)
    else $error("timer 1 overflow gave no baud tick");
  AST_T1_SINGLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ce && t1_active && !baud_double_bit && t1_ovf && !t1_half
    |=> !baud_tick)
    else $error("timer 1 halving failed");
  AST_BRK_MASTER: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(brk_active) |-> $past(lin_master) || lin_master)
    else $error("break started by a non-master");
  AST_BRK_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
    brk_active && ce |=> !lin_txd)
    else $error("line not dominant during break");
  AST_BRK_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(brk_active) |-> bit_cnt >= BRK_MIN_BITS)
    else $error("break shorter than minimum");
  AST_REMEASURE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ce && adopt && lin_en && !meas_err |=> lin_state == ST_WAIT_BRK
    ##0 meas_val == $past(meas_cnt) + 16'h0001)
    else $error("header measurement not rearmed");
  AST_IRQ_LEVEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |(irq_status & irq_mask) |=> irq)
    else $error("interrupt output missing");

  COV_NORMAL_DIVIDER_OVERFLOW_FLAG: cover property (@(posedge sys_clk) disable iff (!rst_n)
    ce && ndiv_ovf);
  COV_SYNC: cover property (@(posedge sys_clk) disable iff (!rst_n)
    ce && adopt);
  COV_BRK: cover property (@(posedge sys_clk) disable iff (!rst_n)
    brk_done);
endmodule

// ### verification/ubd_lin_node.sv
`timescale 1ns/1ps
module ubd_lin_node (
  input  wire logic sys_clk,
  output logic      rxd
);
  // ---------------------------------------------------
  // Remote LIN master sending headers, recessive idle
  // ---------------------------------------------------
  initial rxd = 1'b1;
  task automatic header(input int t, input logic [7:0] b);
    rxd <= 1'b0;
    repeat (14 * t) @(posedge sys_clk);
    rxd <= 1'b1;
    repeat (t) @(posedge sys_clk);
    for (int i = -1; i < 9; i++) begin
      rxd <= (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : b[i];
      repeat (t) @(posedge sys_clk);
    end
  endtask
endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(a,e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  import ubd_pkg::*;
  logic         sys_clk, rst_n, t1_ovf, uart_txd, lin_rxd, ce;
  logic         baud_tick, fmod_tick, lin_txd, irq;
  logic [31:0]  r;
  logic [7:0]   s;
  ubd_ahb_req_t rq, ar;
  ubd_ahb_rsp_t rsp;
  int           num_errors = 0, n_tests = 0, k, bt = 0, n, v, c0;
  always_comb begin ar = rq; ar.hready = rsp.hreadyout; end
  always @(posedge sys_clk) bt <= bt + baud_tick;
  ubd_top u_ubd_top (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
    .ahb_req(ar), .ahb_rsp(rsp), .t1_ovf(t1_ovf), .uart_txd(uart_txd),
    .lin_rxd(lin_rxd), .baud_tick(baud_tick), .fmod_tick(fmod_tick),
    .lin_txd(lin_txd), .irq(irq));
  ubd_lin_node u_ubd_lin_node (.sys_clk(sys_clk), .rxd(lin_rxd));
  // ---------------------------------------------------
  // Bus cycles, expectations, closing
  // ---------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int j = 0;
    rq <= '{1'b1, {24'h0, a}, 2'b10, w, 3'b010, rq.hwdata, 1'b1};
    do @(posedge sys_clk); while (rsp.hreadyout !== 1'b1 && ++j < 99);
    rq.htrans <= 2'b00;
    rq.hsel   <= 1'b0;
    rq.hwdata <= d;
    do @(posedge sys_clk); while (rsp.hreadyout !== 1'b1 && ++j < 99);
    r = rsp.hrdata;
    if (j >= 99) num_errors++;
  endtask
  function automatic int ovf_gap(logic [7:0] st); return 256 - st; endfunction
  function automatic int lin_reload(int m); return (m >> 7) - 1; endfunction
  function automatic int t1_ticks(int p, int dbl); return dbl ? p : p / 2;
  endfunction
  task automatic gap(output int g);
    g = 0;
    k = 0;
    while (fmod_tick !== 1'b1 && k++ < 600) @(negedge sys_clk);
    do begin @(negedge sys_clk); g++; end while (fmod_tick !== 1'b1 && g < 600);
  endtask
  task automatic brk(input logic [31:0] c, output int t);
    t = 0;
    k = 0;
    bus(1'b1, OFS_LIN_CTRL, c);
    while (lin_txd !== 1'b0 && k++ < 50) @(negedge sys_clk);
    while (lin_txd === 1'b0 && k++ < 5000) begin
      t += baud_tick;
      @(negedge sys_clk);
    end
  endtask
  task tally_and_finish;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #300_000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    rq = '0; rst_n = 1'b0; t1_ovf = 1'b0; uart_txd = 1'b1;
    ce = 1'b1;
    void'($urandom(4));
    repeat (12) @(posedge sys_clk);
    `CHK({lin_txd, irq}, 2'h2)
    rst_n <= 1'b1;
    bus(1'b0, OFS_LIN_CTRL, 32'h0);
    `CHK(r, 32'h0000_0d00)
    bus(1'b0, 8'h40, 32'h0);
    `CHK(r, RD_ZERO)
    repeat (8) begin
      v = $urandom_range(1);
      uart_txd <= 1'(v);
      @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK(lin_txd, 1'(v))
      @(posedge sys_clk);
    end
    uart_txd <= 1'b1;
    for (int d = 1; d >= 0; d--) begin
      bus(1'b1, OFS_UART, {28'h0, 1'(d), 3'h5});
      c0 = bt;
      repeat (6) begin
        t1_ovf <= 1'b1;
        @(posedge sys_clk);
        t1_ovf <= 1'b0;
        repeat (3) @(posedge sys_clk);
      end
      `CHK(bt - c0, t1_ticks(6, d))
    end
    bus(1'b1, OFS_UART, 32'h0);
    bus(1'b1, OFS_BAUD, 32'h0001_0001);
    for (int i = 0; i < 2; i++) begin
      s = i ? 8'hfe : 8'($urandom_range(128, 250));
      bus(1'b1, OFS_DIV_STEP, {24'h0, s});
      bus(1'b1, OFS_IRQ_MASK, 32'h1);
      bus(1'b1, OFS_DIV_CTRL, 32'h3);
      repeat (2) @(posedge sys_clk);
      c0 = bt;
      gap(n);
      gap(n);
      `CHK(n, ovf_gap(s))
      `CHK(bt, c0)
      `CHK(irq, 1'b1)
      ce <= 1'b0;
      bus(1'b0, OFS_DIV_RES, 32'h0);
      c0 = int'(r[7:0]);
      bus(1'b0, OFS_DIV_RES, 32'h0);
      `CHK(r[7:0], 8'(c0))
      ce <= 1'b1;
      bus(1'b0, OFS_DIV_RES, 32'h0);
      `CHK(r[7:0] >= s, 1'b1)
      bus(1'b1, OFS_DIV_CTRL, 32'h0);
      bus(1'b1, OFS_IRQ_STAT, 32'h1);
      bus(1'b0, OFS_IRQ_STAT, 32'h0);
      repeat (2) @(negedge sys_clk);
      `CHK({r[0], irq}, 2'h0)
    end
    brk(32'h8000_0d00, n);
    `CHK(n, 0)
    brk(32'h8000_0502, n);
    `CHK(n, 13 * 16)
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    `CHK(r[2], 1'b1)
    brk(32'h8000_1002, n);
    `CHK(n, 16 * 16)
    bus(1'b1, OFS_IRQ_STAT, 32'hf);
    bus(1'b1, OFS_LIN_CTRL, 32'h0000_0d05);
    bus(1'b1, OFS_IRQ_MASK, 32'h2);
    for (int t = 100; t <= 120; t += 20) begin
      u_ubd_lin_node.header(t, 8'h55);
      repeat (5) @(posedge sys_clk);
      bus(1'b0, OFS_LIN_STAT, 32'h0);
      v = int'(r[15:0]) - 8 * t;
      `CHK(v inside {-1, 0, 1}, 1'b1)
      `CHK(irq, 1'b1)
      bus(1'b0, OFS_BAUD, 32'h0);
      `CHK(r[7:0], 8'(lin_reload(8 * t)))
      bus(1'b1, OFS_IRQ_STAT, 32'h2);
    end
    tally_and_finish();
  end
endmodule
